/* File: logic/flash_host_map.svh */
// constants, offsets and timing counts for the flash disk host port controller
// ==========================================================================
// Behaviour
// - write happens only while chip select and write strobe are both low
// - read happens only while chip select and output strobe are both low
// - multiplexed mode: host drives address bits 12..1 on shared lines 11..0
// - falling address-valid edge after reset, before first access, selects multiplexed mode
// - four devices share the window in standard mode, two in multiplexed
`ifndef FLASH_HOST_MAP_SVH
`define FLASH_HOST_MAP_SVH
`define ADDR_W         13
`define DATA_W         16
`define MUX_ADDR_LO    1
`define MUX_AD_W       12
`define BOOT_BLOCK_BYTES 2048
`define MAX_DEV_STD    4
`define MAX_DEV_MUX    2
`define CLK_PERIOD_NS  10
`define T_SETUP_NS     10
`define T_STROBE_NS    40
`define T_HOLD_NS      10
`define T_AVD_NS       20
`define T_RESET_NS     1000
`define T_SETUP_CYC    ((`T_SETUP_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define T_STROBE_CYC   ((`T_STROBE_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define T_HOLD_CYC     ((`T_HOLD_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define T_AVD_CYC      ((`T_AVD_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define T_RESET_CYC    ((`T_RESET_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define CNT_W          8
`endif

/* File: logic/flash_host_pkg.sv */
// types for the flash disk host port controller
package flash_host_pkg;
   // ==========================================================================
   // user request and answer
   typedef struct packed {
      logic        write;
      logic [12:0] addr;
      logic [15:0] wdata;
      logic [1:0]  devSel;
   } req_type;
   typedef struct packed {
      logic [15:0] rdata;
      logic        err;
   } rsp_type;
   typedef enum logic [1:0] {
      PH_IDLE,
      PH_SETUP,
      PH_STROBE,
      PH_HOLD
   } phase_type;
endpackage : flash_host_pkg

/* File: logic/strobe_timer.sv */
// down counter for bus phase lengths
`timescale 1ns/1ps
`include "flash_host_map.svh"
module strobe_timer
(
   // clock and reset
   input  wire logic              clk,
   input  wire logic              rstSync_n,
   input  wire logic              clkEn,
   // control
   input  wire logic              load,
   input  wire logic [`CNT_W-1:0] loadVal,
   output logic                   done
);
   logic [`CNT_W-1:0] count_reg;
   assign done = (count_reg == '0);
   always_ff @(posedge clk or negedge rstSync_n)
      if (!rstSync_n)
         count_reg <= '0;
      else if (clkEn)
         count_reg <= load ? loadVal : (done ? count_reg : count_reg - 8'h01);
endmodule : strobe_timer

/* File: logic/flash_host_ctrl.sv */
// host-side controller driving the flash disk parallel port
`timescale 1ns/1ps
`include "flash_host_map.svh"
module flash_host_ctrl
#(
   parameter int RESET_CYC = `T_RESET_CYC,
   parameter int NUM_DEV   = 1
)
(
   // clock and reset
   input  wire logic                    clk,
   input  wire logic                    rst_n,
   input  wire logic                    clkEn,
   // user side
   input  wire logic                    reqValid,
   output logic                         reqReady,
   input  wire flash_host_pkg::req_type req,
   output logic                         rspValid,
   output flash_host_pkg::rsp_type      rsp,
   input  wire logic                    useMux,
   input  wire logic                    wide16,
   input  wire logic                    powerDown,
   input  wire logic                    lockIn,
   output logic                         attention,
   output logic                         ready,
   // device pins
   output logic                         reset_in_n,
   output logic [`ADDR_W-1:0]           addrOut,
   output logic [`DATA_W-1:0]           dataOut,
   output logic                         dataOe,
   input  wire logic [`DATA_W-1:0]      dataIn,
   output logic [NUM_DEV-1:0]           chipSel_n,
   output logic                         writeStb_n,
   output logic                         outStb_n,
   output logic                         addr_valid_strobe_n,
   output logic                         cascade_identity0,
   output logic                         wideSel,
   output logic                         lockPin_n,
   input  wire logic                    busyIn_n,
   input  wire logic                    attnIn_n
);
   // ==========================================================================
   // parameter check
   if (NUM_DEV < 1 || NUM_DEV > `MAX_DEV_STD || RESET_CYC < 1 || RESET_CYC > 65535)
   begin : g_param_check
      $error("flash_host_ctrl: bad parameters");
   end
   // ==========================================================================
   // reset synchroniser
   logic rstMeta_reg;
   logic rstSync_n;
   always_ff @(posedge clk or negedge rst_n)
      if (!rst_n)
      begin
         rstMeta_reg <= 1'b0;
         rstSync_n   <= 1'b0;
      end
      else
      begin
         rstMeta_reg <= 1'b1;
         rstSync_n   <= rstMeta_reg;
      end
   // ==========================================================================
   // reset pulse to device and mode strap
   logic [15:0] rstCnt_reg;
   logic        devRstDone;
   logic        muxMode_reg;
   logic        avdDone_reg;
   logic        avdLow_reg;
   assign devRstDone = (rstCnt_reg == 16'(RESET_CYC));
   always_ff @(posedge clk or negedge rstSync_n)
      if (!rstSync_n)
         rstCnt_reg <= 16'h0000;
      else if (clkEn && !devRstDone)
         rstCnt_reg <= rstCnt_reg + 16'h0001;
   always_ff @(posedge clk or negedge rstSync_n)
      if (!rstSync_n)
      begin
         muxMode_reg <= 1'b0;
         avdDone_reg <= 1'b0;
         avdLow_reg  <= 1'b0;
      end
      else if (clkEn && devRstDone)
      begin
         if (!avdDone_reg)
         begin
            muxMode_reg <= useMux;
            avdLow_reg  <= useMux;
            avdDone_reg <= 1'b1; // falling edge before first access
         end
         else
            avdLow_reg <= 1'b0;
      end
   assign reset_in_n = devRstDone;
   // ==========================================================================
   // access sequencer
   flash_host_pkg::phase_type phase_reg;
   flash_host_pkg::phase_type phase_next;
   flash_host_pkg::req_type   cur_reg;
   logic [15:0]               rdata_reg;
   logic                      rspValid_reg;
   logic                      timerDone;
   logic                      timerLoad;
   logic [`CNT_W-1:0]         timerVal;
   logic                      devReady;
   logic                      devLegal;
   logic                      take;
   assign devReady = devRstDone && avdDone_reg && busyIn_n; // wait out boot copy
   assign devLegal = (32'(req.devSel) < NUM_DEV) && !(muxMode_reg && req.devSel >= 2'(`MAX_DEV_MUX));
   assign reqReady = (phase_reg == flash_host_pkg::PH_IDLE) && devReady && !avdLow_reg;
   assign take     = reqValid && reqReady;
   always_comb
   begin
      phase_next = phase_reg;
      timerLoad  = 1'b0;
      timerVal   = 8'h00;
      case (phase_reg)
         flash_host_pkg::PH_IDLE:
            if (take && devLegal)
            begin
               phase_next = flash_host_pkg::PH_SETUP;
               timerLoad  = 1'b1;
               timerVal   = 8'(muxMode_reg ? `T_AVD_CYC : `T_SETUP_CYC);
            end
         flash_host_pkg::PH_SETUP:
            if (timerDone)
            begin
               phase_next = flash_host_pkg::PH_STROBE;
               timerLoad  = 1'b1;
               timerVal   = 8'(`T_STROBE_CYC);
            end
         flash_host_pkg::PH_STROBE:
            if (timerDone)
            begin
               phase_next = flash_host_pkg::PH_HOLD;
               timerLoad  = 1'b1;
               timerVal   = 8'(`T_HOLD_CYC);
            end
         flash_host_pkg::PH_HOLD:
            if (timerDone)
               phase_next = flash_host_pkg::PH_IDLE;
         default:
            phase_next = flash_host_pkg::PH_IDLE;
      endcase
   end
   strobe_timer u_timer
   (
      .clk       (clk),
      .rstSync_n (rstSync_n),
      .clkEn     (clkEn),
      .load      (timerLoad),
      .loadVal   (timerVal),
      .done      (timerDone)
   );
   logic endStrobe;
   logic endHold;
   assign endStrobe = (phase_reg == flash_host_pkg::PH_STROBE) && timerDone;
   assign endHold   = (phase_reg == flash_host_pkg::PH_HOLD) && timerDone;
   logic err_reg;
   logic refuse;
   assign refuse = take && !devLegal;
   always_ff @(posedge clk or negedge rstSync_n)
      if (!rstSync_n)
      begin
         phase_reg    <= flash_host_pkg::PH_IDLE;
         rspValid_reg <= 1'b0;
      end
      else if (clkEn)
      begin
         phase_reg    <= phase_next;
         rspValid_reg <= endHold || refuse;
      end
   always_ff @(posedge clk or negedge rstSync_n)
      if (!rstSync_n)
      begin
         cur_reg <= '0;
         err_reg <= 1'b0;
      end
      else if (clkEn && take)
      begin
         cur_reg <= req;
         err_reg <= !devLegal; // refused device, no bus cycle
      end
   always_ff @(posedge clk or negedge rstSync_n)
      if (!rstSync_n)
         rdata_reg <= 16'h0000;
      else if (clkEn && endStrobe && !cur_reg.write)
         rdata_reg <= wide16 ? dataIn : {8'h00, dataIn[7:0]};
   // ==========================================================================
   // response
   assign rspValid = rspValid_reg;
   assign rsp      = '{rdata: rdata_reg, err: err_reg};
   // ==========================================================================
   // pin drive
   logic inSetupMux;
   logic strobing;
   logic active;
   assign active     = (phase_reg != flash_host_pkg::PH_IDLE);
   assign strobing   = (phase_reg == flash_host_pkg::PH_STROBE);
   assign inSetupMux = muxMode_reg && (phase_reg == flash_host_pkg::PH_SETUP);
   assign addr_valid_strobe_n = !(avdLow_reg || (inSetupMux && !timerDone)); // address held past rise
   assign writeStb_n = !(strobing && cur_reg.write);
   assign outStb_n   = !(strobing && !cur_reg.write);
   genvar g;
   generate
      for (g = 0; g < NUM_DEV; g++)
      begin : g_cs
         assign chipSel_n[g] = !(active && (32'(cur_reg.devSel) == g));
      end
   endgenerate
   // bit 0 doubles as power-down in 16-bit mode
   assign addrOut = {muxMode_reg ? 12'h000 : cur_reg.addr[12:1],
                     wide16 ? powerDown : cur_reg.addr[0]};
   assign dataOut = inSetupMux ? {4'h0, cur_reg.addr[12:1]} : cur_reg.wdata;
   assign dataOe  = inSetupMux || (active && cur_reg.write && !(phase_reg == flash_host_pkg::PH_HOLD && timerDone));
   // ==========================================================================
   // straps and status
   assign cascade_identity0 = 1'b0; // first device strap
   assign wideSel   = wide16;
   assign lockPin_n = !lockIn; // hardware lock for protected regions
   assign attention = !attnIn_n;
   assign ready     = devReady;
endmodule : flash_host_ctrl

/* File: verif/flash_host_ctrl_props.sv */
// pin-level assertions for the flash host port controller
`timescale 1ns/1ps
module flash_host_ctrl_props
#(
   parameter int NUM_DEV = 1
)
(
   // clock and reset
   input wire logic               clk,
   input wire logic               rst_n,
   // user side
   input wire logic               wide16,
   input wire logic               powerDown,
   input wire logic               lockIn,
   input wire logic               attention,
   input wire logic               ready,
   // device pins
   input wire logic [12:0]        addrOut,
   input wire logic               dataOe,
   input wire logic [NUM_DEV-1:0] chipSel_n,
   input wire logic               writeStb_n,
   input wire logic               outStb_n,
   input wire logic               addr_valid_strobe_n,
   input wire logic               wideSel,
   input wire logic               lockPin_n,
   input wire logic               attnIn_n
);
   // ==========================================================================
   // pin relations
   default clocking cb @(posedge clk); endclocking
   default disable iff (!rst_n);
   wire idle = &chipSel_n;
   AST_WR_SEL: assert property (!writeStb_n |-> !idle)
      else $error("write strobe without select");
   AST_RD_SEL: assert property (!outStb_n |-> !idle)
      else $error("output strobe without select");
   AST_ONE_STB: assert property (!writeStb_n |-> outStb_n)
      else $error("both strobes low");
   AST_RD_FREE: assert property (!outStb_n |-> !dataOe)
      else $error("data driven during read");
   AST_PIN0: assert property (wide16 && !idle && addr_valid_strobe_n |-> addrOut[0] == powerDown)
      else $error("pin 0 not power-down in 16-bit mode");
   AST_WIDTH: assert property (wideSel == wide16 || wideSel == $past(wide16))
      else $error("width select wrong");
   AST_LOCK: assert property ($rose(lockIn) |-> ##[0:2] !lockPin_n)
      else $error("lock pin not asserted");
   AST_ATTN: assert property ($fell(attnIn_n) |-> ##[0:2] attention)
      else $error("attention not passed on");
   AST_INIT: assert property (!ready |-> idle [*2])
      else $error("access while device initialising");
   AST_AVD: assert property (!addr_valid_strobe_n && !idle |-> dataOe && writeStb_n && outStb_n)
      else $error("address phase without address");
endmodule : flash_host_ctrl_props

/* File: verif/flash_dev_model.sv */
// behavioural flash disk device on the parallel port
`timescale 1ns/1ps
module flash_dev_model
#(
   parameter int BUSY_NS = 200
)
(
   // device pins
   input  wire logic        reset_in_n,
   input  wire logic [12:0] addrOut,
   input  wire logic [15:0] dataOut,
   input  wire logic        chipSel_n,
   input  wire logic        writeStb_n,
   input  wire logic        outStb_n,
   input  wire logic        addr_valid_strobe_n,
   input  wire logic        wideSel,
   input  wire logic        lockPin_n,
   output logic [15:0]      dataIn,
   output logic             busyIn_n,
   output logic             attnIn_n
);
   // ==========================================================================
   // storage and decode
   logic [15:0] mem [0:8191];
   logic [15:0] lastRd;
   logic [12:0] muxAddr;
   logic        muxMode;
   logic        sticky;
   wire  [12:0] rawA = muxMode ? muxAddr : addrOut;
   wire  [12:0] idx = wideSel ? {rawA[12:1], 1'b0} : rawA;
   wire         locked = (!lockPin_n || sticky) && idx[12:11] == 2'b11;
   wire         serial = idx[12:4] == 9'h010;
   wire         rdAct = !chipSel_n && !outStb_n && busyIn_n;
   assign dataIn = rdAct ? (locked ? 16'hFFFF : mem[idx]) : ~lastRd;
   initial
   begin
      for (int i = 0; i < 8192; i++)
         mem[i] = 16'(i) ^ 16'h5A3C;
      lastRd = 16'h0000;
      muxMode = 1'b0;
      sticky = 1'b0;
      attnIn_n = 1'b1;
   end
   always @(dataIn)
      if (rdAct)
         lastRd = dataIn;
   always @(reset_in_n)
      if (!reset_in_n)
         busyIn_n = 1'b0;
      else
         busyIn_n <= #(BUSY_NS) 1'b1;
   always @(posedge addr_valid_strobe_n)
      muxAddr <= {dataOut[11:0], 1'b0};
   always @(negedge reset_in_n or posedge writeStb_n or negedge addr_valid_strobe_n)
   begin
      if (!reset_in_n)
      begin
         muxMode <= 1'b0;
         sticky <= 1'b0;
         attnIn_n <= 1'b1;
      end
      else if (!addr_valid_strobe_n)
         muxMode <= 1'b1;
      else if (!chipSel_n && busyIn_n)
      begin
         if (locked)
            attnIn_n <= 1'b0;
         else if (idx == 13'h0FF0)
            sticky <= sticky | dataOut[0];
         else if (!serial)
         begin
            attnIn_n <= 1'b1;
            mem[idx][7:0] <= dataOut[7:0];
            if (wideSel)
               mem[idx][15:8] <= dataOut[15:8];
         end
      end
   end
endmodule : flash_dev_model

/* File: verif/flash_host_port_protection_tb_top.sv */
// self-checking bench for the flash host port controller
`timescale 1ns/1ps
module flash_host_port_protection_tb_top;
   localparam int NUM_DEV = 1;
   logic clk = 1'b0, rst_n = 1'b0, reqValid = 1'b0, useMux = 1'b0, wide16 = 1'b1, powerDown = 1'b0, lockIn = 1'b0;
   logic reqReady, rspValid, attention, ready, reset_in_n, dataOe, writeStb_n, outStb_n, addr_valid_strobe_n;
   logic cascade_identity0, wideSel, lockPin_n, busyIn_n, attnIn_n;
   logic [12:0] addrOut;
   logic [15:0] dataOut, dataIn, got;
   logic [NUM_DEV-1:0] chipSel_n;
   logic [15:0] shadow [0:8191];
   flash_host_pkg::req_type req = '0;
   flash_host_pkg::rsp_type rsp;
   int seed = 32'hDB21, miscompares = 0, num_checks = 0, cycles = 0;
   always #5 clk = ~clk;
   flash_host_ctrl #(.RESET_CYC(4), .NUM_DEV(NUM_DEV)) i_flash_host_ctrl (.clk(clk), .rst_n(rst_n), .clkEn(1'b1),
      .reqValid(reqValid), .reqReady(reqReady), .req(req), .rspValid(rspValid), .rsp(rsp), .useMux(useMux),
      .wide16(wide16), .powerDown(powerDown), .lockIn(lockIn), .attention(attention), .ready(ready),
      .reset_in_n(reset_in_n), .addrOut(addrOut), .dataOut(dataOut), .dataOe(dataOe), .dataIn(dataIn),
      .chipSel_n(chipSel_n), .writeStb_n(writeStb_n), .outStb_n(outStb_n), .wideSel(wideSel),
      .addr_valid_strobe_n(addr_valid_strobe_n), .cascade_identity0(cascade_identity0),
      .lockPin_n(lockPin_n), .busyIn_n(busyIn_n), .attnIn_n(attnIn_n));
   flash_dev_model i_flash_dev_model (.reset_in_n(reset_in_n), .addrOut(addrOut), .dataOut(dataOut),
      .chipSel_n(chipSel_n[0]), .writeStb_n(writeStb_n), .outStb_n(outStb_n), .wideSel(wideSel),
      .addr_valid_strobe_n(addr_valid_strobe_n), .lockPin_n(lockPin_n), .dataIn(dataIn),
      .busyIn_n(busyIn_n), .attnIn_n(attnIn_n));
   // ==========================================================================
   // checking and bus tasks
   function automatic logic [12:0] idx(input logic [12:0] a);
      return wide16 ? {a[12:1], 1'b0} : a;
   endfunction : idx
   task automatic check(input string what, input logic [15:0] seen, input logic [15:0] exp);
      num_checks++;
      if (seen !== exp)
      begin
         miscompares++;
         $display("[FAIL] %s expected %h seen %h", what, exp, seen);
      end
   endtask : check
   task automatic give_verdict;
      $display("checks %0d mismatches %0d", num_checks, miscompares);
      if (miscompares == 0 && num_checks > 0)
         $display("NO MISMATCHES");
      else
         $display("MISMATCHES SEEN");
      $finish;
   endtask : give_verdict
   task automatic op(input logic wr, input logic [12:0] a, input logic [15:0] d, input logic [1:0] dev);
      req = '{write: wr, addr: a, wdata: d, devSel: dev};
      reqValid = 1'b1;
      for (int n = 0; n < 100 && reqReady !== 1'b1; n++) @(posedge clk) #1;
      @(posedge clk) #1;
      reqValid = 1'b0;
      for (int n = 0; n < 50 && rspValid !== 1'b1; n++) @(posedge clk) #1;
      check("response", {15'h0, rspValid}, 16'h0001);
      got = rsp.rdata;
      check("refusal", {15'h0, rsp.err}, {15'h0, (32'(dev) >= NUM_DEV) || (useMux && dev[1])});
   endtask : op
   task automatic wr(input logic [12:0] a, input logic [15:0] d);
      op(1'b1, a, d, 2'd0);
      shadow[idx(a)][7:0] = d[7:0];
      if (wide16)
         shadow[idx(a)][15:8] = d[15:8];
   endtask : wr
   task automatic rd(input logic [12:0] a);
      op(1'b0, a, 16'h0000, 2'd0);
      check("read data", got, wide16 ? shadow[idx(a)] : {8'h00, shadow[idx(a)][7:0]});
   endtask : rd
   task automatic bringup;
      rst_n = 1'b0;
      repeat (8) @(posedge clk);
      #1 rst_n = 1'b1;
      for (int n = 0; n < 500 && ready !== 1'b1; n++) @(posedge clk) #1;
      check("ready", {15'h0, ready}, 16'h0001);
      check("identity strap", {15'h0, cascade_identity0}, 16'h0000);
   endtask : bringup
   task automatic rnd(input int cnt);
      logic [12:0] a;
      for (int i = 0; i < cnt; i++)
      begin
         a = 13'h0200 + 13'($random(seed) & 32'h7FF);
         powerDown = 1'($random(seed));
         wr(a, 16'($random(seed)));
         rd(a ^ 13'($random(seed) & 32'h1));
      end
   endtask : rnd
   always @(posedge clk)
   begin
      cycles++;
      if (cycles == 20000)
      begin
         miscompares++;
         give_verdict();
      end
   end
   // ==========================================================================
   // scenarios
   initial
   begin
      for (int i = 0; i < 8192; i++)
         shadow[i] = 16'(i) ^ 16'h5A3C;
      bringup();
      op(1'b1, 13'h0104, 16'h1234, 2'd0);
      rd(13'h0104);
      lockIn = 1'b1;
      op(1'b1, 13'h1A00, 16'h0BAD, 2'd0);
      check("attention", {15'h0, attention}, 16'h0001);
      op(1'b0, 13'h1A00, 16'h0000, 2'd0);
      check("locked read", got, 16'hFFFF);
      lockIn = 1'b0;
      wr(13'h1A00, 16'hBEEF);
      rd(13'h1A00);
      check("attention", {15'h0, attention}, 16'h0000);
      op(1'b1, 13'h0FF0, 16'h0001, 2'd0);
      op(1'b1, 13'h0FF0, 16'h0000, 2'd0);
      op(1'b1, 13'h1A00, 16'h0BAD, 2'd0);
      op(1'b0, 13'h1A00, 16'h0000, 2'd0);
      check("sticky read", got, 16'hFFFF);
      op(1'b1, 13'h0300, 16'hCAFE, 2'd1);
      rd(13'h0300);
      rnd(25);
      wide16 = 1'b0;
      rnd(25);
      wide16 = 1'b1;
      useMux = 1'b1;
      bringup();
      rd(13'h1A00);
      op(1'b0, 13'h0300, 16'h0000, 2'd2);
      rnd(25);
      give_verdict();
   end
endmodule : flash_host_port_protection_tb_top
bind flash_host_ctrl flash_host_ctrl_props #(.NUM_DEV(NUM_DEV)) i_flash_host_ctrl_props (.clk(clk), .rst_n(rst_n),
   .wide16(wide16), .powerDown(powerDown), .lockIn(lockIn), .attention(attention), .ready(ready),
   .addrOut(addrOut), .dataOe(dataOe), .chipSel_n(chipSel_n), .writeStb_n(writeStb_n), .outStb_n(outStb_n),
   .addr_valid_strobe_n(addr_valid_strobe_n), .wideSel(wideSel), .lockPin_n(lockPin_n), .attnIn_n(attnIn_n));
